// >>> common/local_decoder_pkg.sv
// shared constants and carrier types for the local memory and i/o decoder
package local_decoder_pkg;
    // bus geometry
    localparam int ADDR_HI = 23;
    localparam int ADDR_LO = 1;
    localparam int BYTE_W = 8;
    // socket pairs and boot redirection
    localparam int PAIR_COUNT = 4;
    localparam logic [1:0] BOOT_PAIR = 2'h3;
    localparam logic [2:0] BOOT_CYCLES = 3'h4;
    // placement prom: indexed by address bits 23 and 19..12 (4 KB granule)
    localparam int PROM_ADDR_W = 9;
    localparam int PROM_DATA_W = 4;
    localparam int GRANULE_LSB = 12;
    localparam int MEG_LSB = 20;
    localparam logic [3:0] MEG_LOW = 4'h0;
    localparam logic [3:0] MEG_HIGH = 4'hf;
    // prom word: bit 3 valid, bit 2 i/o, bits 1..0 pair number
    localparam int PROM_VALID_BIT = 3;
    localparam int PROM_IO_BIT = 2;
    // per-pair device size codes 0..4 give 2K..32K bytes per device
    localparam int SIZE_CODE_W = 3;
    localparam logic [2:0] SIZE_MAX = 3'h4;
    // wait jumper width and 8 MHz processor clock against the 40 MHz block clock
    localparam int WAIT_W = 3;
    localparam int CLOCK_HZ = 40000000;
    localparam int CPU_HZ = 8000000;
    localparam int CPU_RATIO = CLOCK_HZ / CPU_HZ;

    // request from the processor side
    typedef struct packed {
        logic [ADDR_HI:ADDR_LO] addr;
        logic as_n;
        logic lower_byte_strobe_n;
        logic upper_byte_strobe_n;
        logic write_n;
    } cpu_bus_t;

    // selects toward the sockets
    typedef struct packed {
        logic [PAIR_COUNT-1:0] low_sel;
        logic [PAIR_COUNT-1:0] high_sel;
        logic io_sel;
    } socket_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACK = 2'b10,
        ST_HOLD = 2'b11
    } cycle_state_t;
endpackage

// >>> design/local_memory_io_decoder.sv
`timescale 1ns/10ps
// local bus decoder: socket selects, boot redirection, acknowledge timing
// Contract
// - word as two bytes, strobes replace a0
// - each pair: low and high byte halves
// - devices of 2K to 32K per pair
// - first four cycles go to boot pair
// - prom places pairs in low/high megabyte
// - ram acknowledged with no wait states
// - rom wait states set by jumper (here on rom reads only; rom writes get none)
// - i/o in one prom-placed 4 KB segment
// - i/o segment asserts peripheral cycle request
// - status shows live serial one input
module local_memory_io_decoder
    import local_decoder_pkg::*;
#(
    parameter int PAIRS = PAIR_COUNT
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire cpu_bus_t bus_i,
    input wire logic [PAIRS-1:0] pair_is_rom_i,
    input wire logic [PAIRS*SIZE_CODE_W-1:0] pair_size_i,
    input wire logic [WAIT_W-1:0] rom_wait_jumper_i,
    input wire logic prom_wr_i,
    input wire logic [PROM_ADDR_W-1:0] prom_waddr_i,
    input wire logic [PROM_DATA_W-1:0] prom_wdata_i,
    input wire logic serial_port_one_rxd_i,
    output socket_sel_t sel_o,
    output logic [14:0] socket_addr_o,
    output logic dtack_n_o,
    output logic peripheral_cycle_request_n_o,
    output logic serial_rxd_status_o
);
    // ****************************************
    // address decode
    // ****************************************
    logic [PROM_DATA_W-1:0] prom_word;
    cycle_state_t state_reg, state_next;
    logic [2:0] boot_count_reg;
    logic [WAIT_W+3:0] wait_count_reg;
    logic as_q_reg;
    socket_sel_t sel_next;

    wire logic [3:0] addr_meg = {bus_i.addr[ADDR_HI], bus_i.addr[22:MEG_LSB]};
    // window: outside the boot cycles, only lowest and highest megabyte decode
    wire logic in_window = (addr_meg == MEG_LOW) || (addr_meg == MEG_HIGH);
    wire logic [PROM_ADDR_W-1:0] prom_raddr =
        {bus_i.addr[ADDR_HI], bus_i.addr[19:GRANULE_LSB]};
    wire logic booting = boot_count_reg < BOOT_CYCLES;
    wire logic cycle_start = !bus_i.as_n && as_q_reg;
    wire logic prom_valid = prom_word[PROM_VALID_BIT] && in_window;
    // one 4 KB granule flagged as i/o
    wire logic hit_io = prom_valid && prom_word[PROM_IO_BIT] && !booting;
    wire logic [1:0] hit_pair = booting ? BOOT_PAIR : prom_word[1:0];
    wire logic hit_mem = booting || (prom_valid && !prom_word[PROM_IO_BIT]);
    wire logic hit_rom = pair_is_rom_i[hit_pair];
    wire logic [SIZE_CODE_W-1:0] hit_size = pair_size_i[hit_pair*SIZE_CODE_W +: SIZE_CODE_W];
    // rule 7 count: jumper in 8 MHz wait states scaled to block clocks
    wire logic [WAIT_W+3:0] rom_wait_clocks =
        (WAIT_W+4)'(rom_wait_jumper_i) * (WAIT_W+4)'(CPU_RATIO);
    wire logic need_wait = hit_mem && hit_rom && bus_i.write_n && (rom_wait_jumper_i != 0);

    placement_prom #(.AW(PROM_ADDR_W), .DW(PROM_DATA_W)) u_prom (
        .clock_i(clock_i),
        .enable_i(enable_i),
        .wr_i(prom_wr_i),
        .waddr_i(prom_waddr_i),
        .wdata_i(prom_wdata_i),
        .raddr_i(prom_raddr),
        .rdata_o(prom_word)
    );

    // ****************************************
    // socket selects
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : g_pair
            assign sel_next.low_sel[g] = hit_mem && (hit_pair == g) && !bus_i.lower_byte_strobe_n;
            assign sel_next.high_sel[g] = hit_mem && (hit_pair == g) && !bus_i.upper_byte_strobe_n;
        end
    endgenerate
    assign sel_next.io_sel = hit_io && !hit_mem;

    // ****************************************
    // cycle state machine
    // ****************************************
    // prom read is registered, so decide one clock after address strobe falls
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cycle_start) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (bus_i.as_n) begin
                    state_next = ST_IDLE;
                end else if (!need_wait || wait_count_reg >= rom_wait_clocks) begin
                    state_next = (hit_mem || hit_io) ? ST_ACK : ST_HOLD;
                end
            end
            ST_ACK: begin
                if (bus_i.as_n) begin
                    state_next = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (bus_i.as_n) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            as_q_reg <= 1'b1;
            wait_count_reg <= '0;
        end else if (enable_i) begin
            state_reg <= state_next;
            as_q_reg <= bus_i.as_n;
            wait_count_reg <= (state_reg == ST_WAIT) ? wait_count_reg + 1'b1 : '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            boot_count_reg <= '0;
        end else if (enable_i && booting && state_reg != ST_IDLE && bus_i.as_n) begin
            boot_count_reg <= boot_count_reg + 1'b1;
        end
    end

    // outputs from flip-flops
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sel_o <= '0;
            socket_addr_o <= '0;
            dtack_n_o <= 1'b1;
            peripheral_cycle_request_n_o <= 1'b1;
            serial_rxd_status_o <= 1'b1;
        end else if (enable_i) begin
            sel_o <= (state_next != ST_IDLE && state_reg != ST_IDLE) ? sel_next : '0;
            // word address masked to device size
            // a pair of 2K-byte devices holds 2K words, so size code 0 keeps 11 bits
            socket_addr_o <= bus_i.addr[15:1] & ~(15'h7fff << (4'hb + {1'b0, hit_size}));
            dtack_n_o <= !(state_next == ST_ACK && hit_mem);
            peripheral_cycle_request_n_o <= !(state_next == ST_ACK && hit_io && !hit_mem);
            serial_rxd_status_o <= serial_port_one_rxd_i;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_ONE_SELECT: assert property (@(posedge clock_i) disable iff (reset_i)
        $onehot0({|(sel_o.low_sel | sel_o.high_sel), sel_o.io_sel}))
        else $error("more than one select active");
    AST_BOOT_REDIRECT: assert property (@(posedge clock_i) disable iff (reset_i)
        booting |-> ((sel_o.low_sel[2:0] | sel_o.high_sel[2:0]) == 3'h0 && !sel_o.io_sel))
        else $error("boot cycle not sent to boot pair");
    AST_NO_ACK_UNMAPPED: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_reg == ST_HOLD) |-> (dtack_n_o && peripheral_cycle_request_n_o))
        else $error("unmapped address acknowledged");
    AST_ACK_EXCLUSIVE: assert property (@(posedge clock_i) disable iff (reset_i)
        !(!dtack_n_o && !peripheral_cycle_request_n_o))
        else $error("acknowledge and peripheral request together");
    AST_RAM_FAST: assert property (@(posedge clock_i) disable iff (reset_i || !enable_i)
        (state_reg == ST_WAIT && !need_wait && hit_mem && !bus_i.as_n) |=> !dtack_n_o)
        else $error("ram access delayed");
    AST_RXD_LIVE: assert property (@(posedge clock_i) disable iff (reset_i || !enable_i)
        serial_rxd_status_o == $past(serial_port_one_rxd_i))
        else $error("serial status not following input");
endmodule

// >>> design/placement_prom.sv
`timescale 1ns/10ps
// small writable placement table standing in for the decoder prom
module placement_prom
    import local_decoder_pkg::*;
#(
    parameter int AW = PROM_ADDR_W,
    parameter int DW = PROM_DATA_W
) (
    input wire logic clock_i,
    input wire logic enable_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // registered read; contents are loaded before use, no reset by design
    always_ff @(posedge clock_i) begin
        if (enable_i) begin
            if (wr_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

// >>> tb/host_cpu_model.sv
// host processor bus model: one transfer at a time
`timescale 1ns/10ps
module host_cpu_model
    import local_decoder_pkg::*;
(
    input wire logic clock_i,
    input wire logic dtack_n_i,
    input wire logic peripheral_cycle_request_n_i,
    input wire socket_sel_t sel_i,
    input wire logic [14:0] socket_addr_i,
    output cpu_bus_t bus_o
);
    // ****************
    // transfer task
    // ****************
    initial bus_o = '1;
    // n counts 40 MHz clocks, five per 8 MHz state
    task automatic cycle(input logic [23:1] a, input logic [1:0] lu_n, input logic rd,
        output int n, output socket_sel_t s, output logic [14:0] sa, output logic vpa);
        @(posedge clock_i);
        bus_o <= {a, 1'b0, lu_n, rd};
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (dtack_n_i !== 1'b0 && peripheral_cycle_request_n_i !== 1'b0 && n < 60);
        s = sel_i;
        sa = socket_addr_i;
        vpa = !peripheral_cycle_request_n_i;
        // released lines float, so show the inverse, not a stale copy
        bus_o <= {~a, 4'hf};
    endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the local decoder
`timescale 1ns/10ps
module testbench
    import local_decoder_pkg::*;
;
    // ****************
    // harness
    // ****************
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic enable_i = 1'b1;
    logic [3:0] pair_is_rom = 4'ha;
    logic [11:0] pair_size = 12'h924;
    logic [2:0] jumper = 3'h0;
    logic prom_wr = 1'b0;
    logic [8:0] prom_waddr = 9'h0;
    logic [3:0] prom_wdata = 4'h0;
    logic rxd = 1'b1;
    cpu_bus_t bus;
    socket_sel_t sel, s;
    logic [14:0] socket_addr, sa;
    logic dtack_n, req_n, status, vpa;
    int n, base, errors = 0, tests_run = 0, cycles = 0;
    always #12.5 clock_i = ~clock_i;
    local_memory_io_decoder i_dut (.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
        .bus_i(bus), .pair_is_rom_i(pair_is_rom), .pair_size_i(pair_size),
        .rom_wait_jumper_i(jumper), .prom_wr_i(prom_wr), .prom_waddr_i(prom_waddr),
        .prom_wdata_i(prom_wdata), .serial_port_one_rxd_i(rxd), .sel_o(sel),
        .socket_addr_o(socket_addr), .dtack_n_o(dtack_n),
        .peripheral_cycle_request_n_o(req_n), .serial_rxd_status_o(status));
    host_cpu_model i_cpu (.clock_i(clock_i), .dtack_n_i(dtack_n),
        .peripheral_cycle_request_n_i(req_n), .sel_i(sel), .socket_addr_i(socket_addr),
        .bus_o(bus));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [23:1] a, input logic [1:0] lu_n, input logic rd);
        i_cpu.cycle(a, lu_n, rd, n, s, sa, vpa);
    endtask
    // ****************
    // scenarios
    // ****************
    // map: 00f000 ram pair 0, f01000 rom pair 1, fff000 i/o, 005000 invalid
    task automatic test_boot;
        logic [8:0] idx [4] = '{9'h00f, 9'h101, 9'h1ff, 9'h005};
        logic [3:0] dat [4] = '{4'h8, 4'h9, 4'hc, 4'h0};
        logic [23:1] a [4] = '{23'h007800, 23'h7ff800, 23'h280000, 23'h780800};
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            prom_wr <= 1'b1;
            prom_waddr <= idx[i];
            prom_wdata <= dat[i];
        end
        @(posedge clock_i);
        prom_wr <= 1'b0;
        // pair 3 holds the vector rom, so the redirected reads get an answer
        for (int i = 0; i < 4; i++) begin
            run(a[i], 2'b00, 1'b1);
            check(s, {4'h8, 4'h8, 1'b0});
            check({vpa, n < 60}, 2'b01);
        end
        run(23'h7ff800, 2'b00, 1'b1);
        check(s, 9'h1);
        check(vpa, 1'b1);
    endtask
    task automatic test_ram;
        for (int k = 0; k < 3; k++) begin
            run(23'h007800, k[1:0], k[0]);
            check(s, {3'h0, !k[1], 3'h0, !k[0], 1'b0});
            check(n <= 5, 1'b1);
            base = n;
        end
    endtask
    task automatic test_rom;
        for (int j = 0; j < 3; j++) begin
            @(posedge clock_i);
            jumper <= j[2:0];
            run(23'h780800, 2'b00, 1'b1);
            check(n, base + 5 * j);
            check(s, {4'h2, 4'h2, 1'b0});
        end
    endtask
    task automatic test_unmapped;
        logic [23:1] a [2] = '{23'h002800, 23'h280000};
        for (int i = 0; i < 2; i++) begin
            run(a[i], 2'b00, 1'b1);
            check({s, n[7:0]}, {9'h0, 8'd60});
        end
    endtask
    task automatic test_size;
        for (int z = 0; z < 5; z++) begin
            @(posedge clock_i);
            pair_size <= {9'h124, z[2:0]};
            run(23'h007fff, 2'b00, 1'b1);
            check(sa, ((32'h1 << (11 + z)) - 1) & 32'h7fff);
        end
    endtask
    task automatic test_serial;
        for (int v = 0; v < 2; v++) begin
            @(posedge clock_i);
            rxd <= v[0];
            repeat (2) @(posedge clock_i);
            #1 check(status, v[0]);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // cut a hang short well past the expected run length
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test;
        end
    end
    initial begin
        repeat (20) @(posedge clock_i);
        #1 check({sel, dtack_n, req_n, status}, 12'h007);
        @(posedge clock_i);
        reset_i <= 1'b0;
        test_boot;
        test_ram;
        test_rom;
        test_unmapped;
        test_size;
        test_serial;
        stop_test;
    end
endmodule
